// File: logic/cache_tlb_pkg.sv
// Constants, types and helper functions for cache and TLB way reduction
// Summary of operation
// - Count tag and data parity errors per instruction way
// - Count tag, correctable, raw data errors per data way
// - Count tag and data errors per level-2 way
// - Errors above threshold per window trigger reduction
// - Last instruction way: invalidate it, report degradation
// - Else invalidate instruction way, retire it, report
// - Last data way: invalidate it, report degradation
// - Else invalidate data way, retire it, report
// - Write dirty data lines back before invalidating
// - Defer bit holds level-2 reduction until cleared
// - Last level-2 way: invalidate, keep it, report
// - Else invalidate all available ways, retire, report
// - Parity on TLB fields, lock bit majority vote
// - Software read parity error: demap, set urgent flag
// - Set-assoc TLB translation error: demap silently
// - Bad full-assoc tag never hits; locked misses
// - Full-assoc data parity checked only on tag match
// - Fetch data error: instruction exception, record index
// - Load/store data error: data exception, record index
// - Count TLB errors per way against threshold
// - One TLB way left: reactivate reduced way first
// - Then retire TLB way, invalidate it, report
package cache_tlb_pkg;

  // =========================================================
  // Timing and thresholds
  localparam int CLK_MHZ    = 125;
  localparam int WIN_NS     = 1000;
  localparam int WIN_CYC    = WIN_NS * CLK_MHZ / 1000;
  localparam int WIN_W      = 8;
  localparam int ERR_THRESH = 4;
  localparam int CNT_W      = 4;
  localparam int INC_W      = 3;

  // =========================================================
  // Array geometry and reset values
  localparam int IDX_W = 6;
  localparam int TAG_W = 16;
  localparam int TLB_I = 0;
  localparam int TLB_D = 1;
  localparam logic [1:0] L1_ACT_RST  = 2'h3;
  localparam logic [3:0] L2_ACT_RST  = 4'hF;
  localparam logic [1:0] TLB_ACT_RST = 2'h3;

  typedef logic [IDX_W-1:0] idx_t;
  typedef logic [INC_W-1:0] inc_t;

  // =========================================================
  // Helpers
  function automatic inc_t add4(input logic a, input logic b, input logic c, input logic d);
    return inc_t'({2'h0, a}) + inc_t'({2'h0, b}) + inc_t'({2'h0, c}) + inc_t'({2'h0, d});
  endfunction

  function automatic logic one_left(input logic [3:0] a);
    return (a != 4'h0) && ((a & (a - 4'h1)) == 4'h0);
  endfunction

  function automatic logic maj3(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

endpackage

// File: logic/cache_tlb_way_reduction.sv
// Error-driven way reduction for level-1, level-2 caches and TLBs
`timescale 1ns/1ps
module cache_tlb_way_reduction (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       srst,
  // Level-1 instruction cache error events, one bit per way
  input  wire logic [1:0]                 l1i_tag_perr,
  input  wire logic [1:0]                 l1i_data_perr,
  // Level-1 data cache error events
  input  wire logic [1:0]                 l1d_tag_perr,
  input  wire logic [1:0]                 l1d_data_ce,
  input  wire logic [1:0]                 l1d_data_raw_ue,
  // Level-2 cache error events and control
  input  wire logic [3:0]                 l2_tag_ce,
  input  wire logic [3:0]                 l2_tag_ue,
  input  wire logic [3:0]                 l2_data_ce,
  input  wire logic [3:0]                 l2_data_raw_ue,
  input  wire logic                       reduction_defer_bit,
  // Software alternate-space TLB reads, index 0 instruction, 1 data
  input  wire logic [1:0]                 tlb_asi_rd,
  input  wire logic [1:0]                 tlb_asi_perr,
  input  cache_tlb_pkg::idx_t             tlb_asi_idx [2],
  // Translation lookups, index 0 fetch, 1 load/store
  input  wire logic [1:0]                 xl_valid,
  input  wire logic [1:0]                 xl_set_assoc_tlb_perr,
  input  wire logic [1:0]                 xl_set_assoc_tlb_way,
  input  cache_tlb_pkg::idx_t             xl_set_assoc_tlb_idx [2],
  input  wire logic [1:0]                 xl_full_assoc_tlb_match,
  input  wire logic [cache_tlb_pkg::TAG_W-1:0] xl_full_assoc_tlb_tag [2],
  input  wire logic [1:0]                 xl_full_assoc_tlb_tag_par,
  input  wire logic [2:0]                 xl_full_assoc_tlb_lock3 [2],
  input  wire logic [1:0]                 xl_full_assoc_tlb_data_perr,
  input  cache_tlb_pkg::idx_t             xl_full_assoc_tlb_idx [2],
  // Software clears of sticky flags
  input  wire logic                       degrade_clr,
  input  wire logic [1:0]                 urgent_clr,
  // Cache way commands and state
  output logic [1:0]                      l1i_inval_way_q,
  output logic [1:0]                      l1i_active_q,
  output logic [1:0]                      l1d_wb_inval_way_q,
  output logic [1:0]                      l1d_active_q,
  output logic [3:0]                      l2_inval_way_q,
  output logic [3:0]                      l2_active_q,
  output logic [3:0]                      l2_pending_q,
  output logic                            degradation_error_flag_q,
  // TLB commands and state
  output logic [1:0]                      set_assoc_tlb_inval_way_q [2],
  output logic [1:0]                      set_assoc_tlb_active_q [2],
  output logic [1:0]                      demap_q,
  output cache_tlb_pkg::idx_t             demap_idx_q [2],
  output logic                            urgent_instr_tlb_flag_q,
  output logic                            urgent_data_tlb_flag_q,
  // Full-associative lookup results and precise errors
  output logic [1:0]                      full_assoc_tlb_hit_q,
  output logic [1:0]                      full_assoc_tlb_locked_q,
  output logic [1:0]                      full_assoc_tlb_lock_miss_q,
  output logic                            instr_access_err_q,
  output logic                            data_access_err_q,
  output logic [cache_tlb_pkg::IDX_W:0]   instruction_fault_status_q,
  output logic [cache_tlb_pkg::IDX_W:0]   data_fault_status_q
);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  // =========================================================
  // Error counters
  way_evt_if #(.N(2)) l1i_ev ();
  way_evt_if #(.N(2)) l1d_ev ();
  way_evt_if #(.N(4)) l2_ev ();

  for (genvar w = 0; w < 2; w++) begin : g_l1
    assign l1i_ev.inc[w] = cache_tlb_pkg::add4(l1i_tag_perr[w], l1i_data_perr[w],
                                               1'b0, 1'b0);
    assign l1d_ev.inc[w] = cache_tlb_pkg::add4(l1d_tag_perr[w], l1d_data_ce[w],
                                               l1d_data_raw_ue[w], 1'b0);
  end

  for (genvar w = 0; w < 4; w++) begin : g_l2
    assign l2_ev.inc[w] = cache_tlb_pkg::add4(l2_tag_ce[w], l2_tag_ue[w],
                                              l2_data_ce[w], l2_data_raw_ue[w]);
  end

  way_err_counter #(.N(2)) u_l1i_cnt (.sys_clk(sys_clk), .srst(srst), .ev(l1i_ev));
  way_err_counter #(.N(2)) u_l1d_cnt (.sys_clk(sys_clk), .srst(srst), .ev(l1d_ev));
  way_err_counter #(.N(4)) u_l2_cnt  (.sys_clk(sys_clk), .srst(srst), .ev(l2_ev));

  // =========================================================
  // Level-1 reduction
  wire [1:0] l1i_red;
  wire [1:0] l1d_red;
  wire [1:0] l1i_keep;
  wire [1:0] l1d_keep;

  assign l1i_red  = l1i_ev.reduce;
  assign l1d_red  = l1d_ev.reduce;
  // Never retire the last way: it is only flushed
  assign l1i_keep = ((l1i_active_q & ~l1i_red) == 2'h0) ? l1i_active_q
                                                        : (l1i_active_q & ~l1i_red);
  assign l1d_keep = ((l1d_active_q & ~l1d_red) == 2'h0) ? l1d_active_q
                                                        : (l1d_active_q & ~l1d_red);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      l1i_active_q       <= cache_tlb_pkg::L1_ACT_RST;
      l1d_active_q       <= cache_tlb_pkg::L1_ACT_RST;
      l1i_inval_way_q    <= 2'h0;
      l1d_wb_inval_way_q <= 2'h0;
    end else begin
      l1i_active_q       <= l1i_keep;
      l1d_active_q       <= l1d_keep;
      l1i_inval_way_q    <= l1i_red;
      l1d_wb_inval_way_q <= l1d_red;
    end
  end

  // =========================================================
  // Level-2 reduction, serialised lowest pending way first
  wire [3:0] l2_sel;
  wire       l2_go;
  wire       l2_last;

  assign l2_sel  = l2_pending_q & (~l2_pending_q + 4'h1);
  assign l2_go   = !reduction_defer_bit && (l2_pending_q != 4'h0);
  assign l2_last = cache_tlb_pkg::one_left(l2_active_q);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      l2_pending_q <= 4'h0;
    end else begin
      l2_pending_q <= (l2_pending_q & ~(l2_go ? l2_sel : 4'h0)) | l2_ev.reduce;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      l2_active_q    <= cache_tlb_pkg::L2_ACT_RST;
      l2_inval_way_q <= 4'h0;
    end else if (l2_go && l2_last) begin
      l2_inval_way_q <= l2_sel;
    end else if (l2_go) begin
      l2_inval_way_q <= l2_active_q | l2_sel;
      l2_active_q    <= l2_active_q & ~l2_sel;
    end else begin
      l2_inval_way_q <= 4'h0;
    end
  end

  // =========================================================
  // TLB parity handling and set-associative reduction
  logic [1:0] tag_err;
  logic [1:0] locked;
  logic [1:0] hit;
  logic [1:0] asi_err;
  logic [1:0] set_assoc_tlb_err;
  logic [1:0] dat_err;
  logic [1:0] set_assoc_tlb_red [2];
  logic [1:0] urgent_q;
  logic [1:0] exc_q;
  logic [cache_tlb_pkg::IDX_W:0] fault_q [2];

  for (genvar t = 0; t < 2; t++) begin : g_tlb
    way_evt_if #(.N(2)) s_ev ();
    wire [1:0] base;

    for (genvar w = 0; w < 2; w++) begin : g_w
      assign s_ev.inc[w] = cache_tlb_pkg::add4(set_assoc_tlb_err[t] && (xl_set_assoc_tlb_way[t] == 1'(w)),
                                               1'b0, 1'b0, 1'b0);
    end
    way_err_counter #(.N(2)) u_cnt (.sys_clk(sys_clk), .srst(srst), .ev(s_ev));
    assign set_assoc_tlb_red[t] = s_ev.reduce;
    assign base = cache_tlb_pkg::one_left({2'h0, set_assoc_tlb_active_q[t]}) ? 2'h3
                                                                  : set_assoc_tlb_active_q[t];

    assign tag_err[t]  = ^{xl_full_assoc_tlb_tag[t], xl_full_assoc_tlb_tag_par[t]};
    assign locked[t]   = cache_tlb_pkg::maj3(xl_full_assoc_tlb_lock3[t]);
    assign hit[t]      = xl_valid[t] && xl_full_assoc_tlb_match[t] && !tag_err[t];
    assign dat_err[t]  = hit[t] && xl_full_assoc_tlb_data_perr[t];
    assign asi_err[t]  = tlb_asi_rd[t] && tlb_asi_perr[t];
    assign set_assoc_tlb_err[t] = xl_valid[t] && xl_set_assoc_tlb_perr[t];

    always_ff @(posedge sys_clk) begin
      if (srst) begin
        set_assoc_tlb_active_q[t]    <= cache_tlb_pkg::TLB_ACT_RST;
        set_assoc_tlb_inval_way_q[t] <= 2'h0;
      end else begin
        // Simultaneous reduction pulses on both ways keep the reactivated set
        set_assoc_tlb_active_q[t]    <= ((base & ~set_assoc_tlb_red[t]) == 2'h0 || set_assoc_tlb_red[t] == 2'h0)
                               ? (set_assoc_tlb_red[t] == 2'h0 ? set_assoc_tlb_active_q[t] : base)
                               : (base & ~set_assoc_tlb_red[t]);
        set_assoc_tlb_inval_way_q[t] <= set_assoc_tlb_red[t];
      end
    end

    always_ff @(posedge sys_clk) begin
      if (srst) begin
        demap_q[t]     <= 1'b0;
        demap_idx_q[t] <= '0;
      end else begin
        demap_q[t]     <= asi_err[t] || set_assoc_tlb_err[t];
        demap_idx_q[t] <= asi_err[t] ? tlb_asi_idx[t] : xl_set_assoc_tlb_idx[t];
      end
    end

    always_ff @(posedge sys_clk) begin
      if (srst) begin
        urgent_q[t]         <= 1'b0;
        full_assoc_tlb_hit_q[t]       <= 1'b0;
        full_assoc_tlb_locked_q[t]    <= 1'b0;
        full_assoc_tlb_lock_miss_q[t] <= 1'b0;
        exc_q[t]            <= 1'b0;
        fault_q[t]          <= '0;
      end else begin
        urgent_q[t]         <= asi_err[t] || (urgent_q[t] && !urgent_clr[t]);
        full_assoc_tlb_hit_q[t]       <= hit[t];
        full_assoc_tlb_locked_q[t]    <= hit[t] && locked[t];
        full_assoc_tlb_lock_miss_q[t] <= xl_valid[t] && xl_full_assoc_tlb_match[t] && tag_err[t] && locked[t];
        exc_q[t]            <= dat_err[t];
        fault_q[t]          <= dat_err[t] ? {1'b1, xl_full_assoc_tlb_idx[t]} : fault_q[t];
      end
    end
  end

  assign urgent_instr_tlb_flag_q    = urgent_q[cache_tlb_pkg::TLB_I];
  assign urgent_data_tlb_flag_q     = urgent_q[cache_tlb_pkg::TLB_D];
  assign instr_access_err_q         = exc_q[cache_tlb_pkg::TLB_I];
  assign data_access_err_q          = exc_q[cache_tlb_pkg::TLB_D];
  assign instruction_fault_status_q = fault_q[cache_tlb_pkg::TLB_I];
  assign data_fault_status_q        = fault_q[cache_tlb_pkg::TLB_D];

  // =========================================================
  // Degradation report, set wins over clear
  wire degrade_set;

  assign degrade_set = (l1i_red != 2'h0) || (l1d_red != 2'h0) || l2_go
                       || (set_assoc_tlb_red[0] != 2'h0) || (set_assoc_tlb_red[1] != 2'h0);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      degradation_error_flag_q <= 1'b0;
    end else begin
      degradation_error_flag_q <= degrade_set || (degradation_error_flag_q && !degrade_clr);
    end
  end

  // =========================================================
  // Checks
  l1i_retire_a: assert property (
    (l1i_red == 2'h1 && l1i_active_q == 2'h3)
    |=> (l1i_active_q == 2'h2 && l1i_inval_way_q == 2'h1 && degradation_error_flag_q))
    else $error("instruction way not retired");

  l1i_last_a: assert property (
    (l1i_red != 2'h0 && l1i_active_q != 2'h3) |=> ($stable(l1i_active_q)
    && l1i_inval_way_q == $past(l1i_red) && degradation_error_flag_q))
    else $error("last instruction way mishandled");

  l1d_retire_a: assert property (
    (l1d_red == 2'h2 && l1d_active_q == 2'h3)
    |=> (l1d_active_q == 2'h1 && l1d_wb_inval_way_q == 2'h2))
    else $error("data way not retired");

  l2_defer_a: assert property (
    reduction_defer_bit |=> (l2_inval_way_q == 4'h0))
    else $error("level-2 reduction ran while deferred");

  l2_last_a: assert property (
    (l2_go && l2_last) |=> ($stable(l2_active_q) && l2_inval_way_q == $past(l2_sel)))
    else $error("last level-2 way mishandled");

  l2_flush_all_a: assert property (
    (l2_go && !l2_last) |=> (l2_inval_way_q == $past(l2_active_q | l2_sel)
    && (l2_active_q & $past(l2_sel)) == 4'h0))
    else $error("level-2 way not retired");

  asi_demap_a: assert property (
    asi_err[0] |=> (demap_q[0] && urgent_instr_tlb_flag_q && demap_idx_q[0] == $past(tlb_asi_idx[0])))
    else $error("software read error not demapped");

  set_assoc_tlb_silent_a: assert property (
    (set_assoc_tlb_err[1] && !asi_err[1]) |=> (demap_q[1] && !$rose(urgent_data_tlb_flag_q)))
    else $error("translation error not silently demapped");

  full_assoc_tlb_tag_a: assert property (
    (xl_valid[0] && tag_err[0]) |=> !full_assoc_tlb_hit_q[0])
    else $error("bad tag produced a hit");

  full_assoc_data_tlb_exc_a: assert property (
    dat_err[1] |=> (data_access_err_q && data_fault_status_q == {1'b1, $past(xl_full_assoc_tlb_idx[1])}))
    else $error("data access error not raised");

  set_assoc_tlb_reduce_a: assert property (
    (set_assoc_tlb_red[0] == 2'h1 && set_assoc_tlb_active_q[0] == 2'h1)
    |=> (set_assoc_tlb_active_q[0] == 2'h2 && set_assoc_tlb_inval_way_q[0] == 2'h1))
    else $error("TLB way not reactivated and retired");

  degrade_hold_a: assert property (
    (degrade_set && degrade_clr) |=> degradation_error_flag_q)
    else $error("degradation report lost on clear");

endmodule

// File: logic/way_err_counter.sv
// Windowed per-way error counter raising a reduction pulse
`timescale 1ns/1ps
module way_err_counter #(
  parameter int N = 2
) (
  // Clock and reset
  input wire logic   sys_clk,
  input wire logic   srst,
  // Events and reduction pulses
  way_evt_if.counter ev
);

  logic [cache_tlb_pkg::WIN_W-1:0] win_q;
  logic [cache_tlb_pkg::CNT_W-1:0] cnt_q [N];
  logic [cache_tlb_pkg::CNT_W-1:0] sum   [N];
  logic [N-1:0]                    over;
  logic [N-1:0]                    red_q;
  wire                             win_end;

  assign win_end = (win_q == cache_tlb_pkg::WIN_W'(cache_tlb_pkg::WIN_CYC - 1));
  assign ev.reduce = red_q;

  for (genvar i = 0; i < N; i++) begin : g_way
    assign sum[i]  = cnt_q[i] + cache_tlb_pkg::CNT_W'(ev.inc[i]);
    assign over[i] = sum[i] > cache_tlb_pkg::CNT_W'(cache_tlb_pkg::ERR_THRESH);

    always_ff @(posedge sys_clk) begin
      if (srst || win_end || over[i]) begin
        cnt_q[i] <= '0;
      end else begin
        cnt_q[i] <= sum[i];
      end
    end

    cnt_bound_a: assert property (@(posedge sys_clk) disable iff (srst)
      cnt_q[i] <= cache_tlb_pkg::CNT_W'(cache_tlb_pkg::ERR_THRESH))
      else $error("error count above threshold");
  end

  always_ff @(posedge sys_clk) begin
    if (srst || win_end) begin
      win_q <= '0;
    end else begin
      win_q <= win_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      red_q <= '0;
    end else begin
      red_q <= over;
    end
  end

  win_wrap_a: assert property (@(posedge sys_clk) disable iff (srst)
    win_end |=> (win_q == '0))
    else $error("window did not restart");

endmodule

// File: logic/way_evt_if.sv
// Per-way error increments in, reduction pulses out
`timescale 1ns/1ps
interface way_evt_if #(parameter int N = 2) ();
  cache_tlb_pkg::inc_t [N-1:0] inc;
  logic [N-1:0]                reduce;
  modport counter (input inc, output reduce);
  modport owner   (output inc, input reduce);
endinterface

// File: tb/err_array_model.sv
// Cache array model raising per-way error event pulses
`timescale 1ns/1ps
module err_array_model (
  // Clock
  input  wire logic  sys_clk,
  // Level-1 event pulses
  output logic [1:0] l1i_tag_perr,
  output logic [1:0] l1i_data_perr,
  output logic [1:0] l1d_tag_perr,
  output logic [1:0] l1d_data_ce,
  output logic [1:0] l1d_data_raw_ue,
  // Level-2 event pulses
  output logic [3:0] l2_tag_ce,
  output logic [3:0] l2_tag_ue,
  output logic [3:0] l2_data_ce,
  output logic [3:0] l2_data_raw_ue
);
  // ==========================================================
  // Event groups, one detector line per way
  logic [3:0] ev [9] = '{default: 4'h0};

  assign l1i_tag_perr    = ev[0][1:0];
  assign l1i_data_perr   = ev[1][1:0];
  assign l1d_tag_perr    = ev[2][1:0];
  assign l1d_data_ce     = ev[3][1:0];
  assign l1d_data_raw_ue = ev[4][1:0];
  assign l2_tag_ce       = ev[5];
  assign l2_tag_ue       = ev[6];
  assign l2_data_ce      = ev[7];
  assign l2_data_raw_ue  = ev[8];

  // ==========================================================
  // Pulse train of n cycles; driven 1 ns after an edge
  task automatic pulse(input int g, input logic [3:0] w, input int n);
    @(posedge sys_clk);
    #1 ev[g] = w;
    repeat (n) @(posedge sys_clk);
    #1 ev[g] = 4'h0;
  endtask
endmodule

// File: tb/tb_top.sv
// Self-checking bench for cache and TLB way reduction
`timescale 1ns/1ps
module tb_top;
  // ==========================================================
  // Signals
  logic       sys_clk = 1'b0;
  logic       srst = 1'b1;
  logic [1:0] l1i_tag_perr, l1i_data_perr, l1d_tag_perr, l1d_data_ce, l1d_data_raw_ue;
  logic [3:0] l2_tag_ce, l2_tag_ue, l2_data_ce, l2_data_raw_ue;
  logic       reduction_defer_bit = 1'b0, degrade_clr = 1'b0;
  logic [1:0] tlb_asi_rd = 2'h0, tlb_asi_perr = 2'h0, urgent_clr = 2'h0, xl_valid = 2'h0;
  logic [1:0] xl_set_assoc_tlb_perr = 2'h0, xl_set_assoc_tlb_way = 2'h0, xl_full_assoc_tlb_match = 2'h0;
  logic [1:0] xl_full_assoc_tlb_tag_par = 2'h0, xl_full_assoc_tlb_data_perr = 2'h0;
  cache_tlb_pkg::idx_t tlb_asi_idx [2] = '{6'h0, 6'h0};
  cache_tlb_pkg::idx_t xl_set_assoc_tlb_idx [2] = '{6'h0, 6'h0};
  cache_tlb_pkg::idx_t xl_full_assoc_tlb_idx [2] = '{6'h0, 6'h0};
  cache_tlb_pkg::idx_t demap_idx_q [2];
  logic [cache_tlb_pkg::TAG_W-1:0] xl_full_assoc_tlb_tag [2] = '{16'h0, 16'h0};
  logic [2:0] xl_full_assoc_tlb_lock3 [2] = '{3'h0, 3'h0};
  logic [1:0] l1i_inval_way_q, l1i_active_q, l1d_wb_inval_way_q, l1d_active_q;
  logic [3:0] l2_inval_way_q, l2_active_q, l2_pending_q;
  logic [1:0] demap_q, full_assoc_tlb_hit_q, full_assoc_tlb_locked_q, full_assoc_tlb_lock_miss_q;
  logic [1:0] set_assoc_tlb_inval_way_q [2], set_assoc_tlb_active_q [2];
  logic       degradation_error_flag_q, urgent_instr_tlb_flag_q, urgent_data_tlb_flag_q;
  logic       instr_access_err_q, data_access_err_q;
  logic [cache_tlb_pkg::IDX_W:0] instruction_fault_status_q, data_fault_status_q;
  int         n_mismatch = 0;
  int         num_checks = 0;
  int         cyc = 0;

  always #4 sys_clk = ~sys_clk;
  // Tracks the error window phase counted from reset release
  always @(posedge sys_clk) cyc <= srst ? 0 : cyc + 1;

  err_array_model err_array_model_i (.sys_clk, .l1i_tag_perr, .l1i_data_perr, .l1d_tag_perr,
    .l1d_data_ce, .l1d_data_raw_ue, .l2_tag_ce, .l2_tag_ue, .l2_data_ce, .l2_data_raw_ue);

  cache_tlb_way_reduction cache_tlb_way_reduction_i (.sys_clk, .srst, .l1i_tag_perr,
    .l1i_data_perr, .l1d_tag_perr, .l1d_data_ce, .l1d_data_raw_ue, .l2_tag_ce, .l2_tag_ue,
    .l2_data_ce, .l2_data_raw_ue, .reduction_defer_bit, .tlb_asi_rd, .tlb_asi_perr,
    .tlb_asi_idx, .xl_valid, .xl_set_assoc_tlb_perr, .xl_set_assoc_tlb_way, .xl_set_assoc_tlb_idx, .xl_full_assoc_tlb_match,
    .xl_full_assoc_tlb_tag, .xl_full_assoc_tlb_tag_par, .xl_full_assoc_tlb_lock3, .xl_full_assoc_tlb_data_perr, .xl_full_assoc_tlb_idx,
    .degrade_clr, .urgent_clr, .l1i_inval_way_q, .l1i_active_q, .l1d_wb_inval_way_q,
    .l1d_active_q, .l2_inval_way_q, .l2_active_q, .l2_pending_q, .degradation_error_flag_q,
    .set_assoc_tlb_inval_way_q, .set_assoc_tlb_active_q, .demap_q, .demap_idx_q, .urgent_instr_tlb_flag_q,
    .urgent_data_tlb_flag_q, .full_assoc_tlb_hit_q, .full_assoc_tlb_locked_q, .full_assoc_tlb_lock_miss_q,
    .instr_access_err_q, .data_access_err_q, .instruction_fault_status_q,
    .data_fault_status_q);

  // ==========================================================
  // Helpers
  task automatic summarize();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // Early in a window so a burst never straddles the wrap cycle
  task automatic align();
    while (cyc % 125 != 3) @(posedge sys_clk);
    #1;
  endtask

  task automatic dclr();
    degrade_clr = 1'b1;
    step(1);
    degrade_clr = 1'b0;
    step(1);
  endtask

  task automatic wait_l2();
    int k;
    k = 0;
    while (l2_inval_way_q === 4'h0 && k < 8) begin
      step(1);
      k++;
    end
  endtask

  task automatic xl(input int t, input logic [15:0] tg, input logic [2:0] lk);
    xl_valid[t] = 1'b1;
    xl_full_assoc_tlb_match[t] = 1'b1;
    xl_full_assoc_tlb_tag[t] = tg;
    xl_full_assoc_tlb_lock3[t] = lk;
    xl_full_assoc_tlb_data_perr[t] = 1'b1;
    xl_full_assoc_tlb_idx[t] = 6'(5 + t);
    step(1);
    xl_valid = 2'h0;
    xl_full_assoc_tlb_match = 2'h0;
    xl_full_assoc_tlb_data_perr = 2'h0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_thresh();
    for (int n = 0; n < 2; n++) begin
      align();
      err_array_model_i.pulse(2, 4'h1, 4);
      repeat (4) begin
        step(1);
        chk(8'(l1d_wb_inval_way_q), 8'h0);
      end
    end
  endtask

  task automatic t_l1();
    align();
    err_array_model_i.pulse(0, 4'h1, 5);
    step(1);
    chk(8'({l1i_inval_way_q, l1i_active_q}), 8'h6);
    chk(8'(degradation_error_flag_q), 8'h1);
    step(1);
    chk(8'(l1i_inval_way_q), 8'h0);
    dclr();
    chk(8'(degradation_error_flag_q), 8'h0);
    fork
      err_array_model_i.pulse(0, 4'h2, 3);
      err_array_model_i.pulse(1, 4'h2, 3);
    join
    step(1);
    chk(8'({l1i_inval_way_q, l1i_active_q, degradation_error_flag_q}), 8'h15);
    align();
    err_array_model_i.pulse(2, 4'h2, 2);
    err_array_model_i.pulse(3, 4'h2, 2);
    err_array_model_i.pulse(4, 4'h2, 1);
    step(1);
    chk(8'({l1d_wb_inval_way_q, l1d_active_q}), 8'h9);
    fork
      err_array_model_i.pulse(3, 4'h1, 3);
      err_array_model_i.pulse(4, 4'h1, 3);
    join
    step(1);
    chk(8'({l1d_wb_inval_way_q, l1d_active_q}), 8'h5);
  endtask

  task automatic t_l2();
    logic [3:0] w [3] = '{4'h1, 4'h2, 4'h8};
    logic [7:0] e [3] = '{8'hBA, 8'hA8, 8'h88};
    dclr();
    align();
    reduction_defer_bit = 1'b1;
    fork
      err_array_model_i.pulse(5, 4'h4, 2);
      err_array_model_i.pulse(6, 4'h4, 1);
      err_array_model_i.pulse(7, 4'h4, 1);
      err_array_model_i.pulse(8, 4'h4, 1);
    join
    step(4);
    chk(8'({l2_inval_way_q, l2_pending_q}), 8'h04);
    step(3);
    chk(8'({l2_inval_way_q, l2_pending_q}), 8'h04);
    reduction_defer_bit = 1'b0;
    wait_l2();
    chk(8'({l2_inval_way_q, l2_active_q}), 8'hFB);
    chk(8'(degradation_error_flag_q), 8'h1);
    step(1);
    chk(8'({l2_inval_way_q, l2_pending_q}), 8'h00);
    align();
    for (int i = 0; i < 3; i++) begin
      err_array_model_i.pulse(7, w[i], 5);
      wait_l2();
      chk(8'({l2_inval_way_q, l2_active_q}), e[i]);
      step(1);
    end
  endtask

  task automatic t_asi();
    logic [7:0] e [2] = '{8'h49, 8'h8A};
    tlb_asi_rd = 2'h3;
    tlb_asi_idx = '{6'h9, 6'hA};
    step(1);
    chk(8'({demap_q, urgent_data_tlb_flag_q, urgent_instr_tlb_flag_q}), 8'h0);
    for (int t = 0; t < 2; t++) begin
      tlb_asi_rd = 2'(1 << t);
      tlb_asi_perr = 2'(1 << t);
      step(1);
      chk(8'({demap_q, demap_idx_q[t]}), e[t]);
      chk(8'({urgent_data_tlb_flag_q, urgent_instr_tlb_flag_q}), 8'((2 << t) - 1));
    end
    tlb_asi_rd = 2'h0;
    tlb_asi_perr = 2'h0;
    urgent_clr = 2'h3;
    step(1);
    urgent_clr = 2'h0;
    step(1);
    chk(8'({demap_q, urgent_data_tlb_flag_q, urgent_instr_tlb_flag_q}), 8'h0);
  endtask

  task automatic t_set_assoc_tlb();
    logic [7:0] e [2] = '{8'h6, 8'h9};
    dclr();
    align();
    for (int w = 0; w < 2; w++) begin
      xl_valid = 2'h2;
      xl_set_assoc_tlb_perr = 2'h2;
      xl_set_assoc_tlb_way = (w == 0) ? 2'h0 : 2'h2;
      xl_set_assoc_tlb_idx[1] = 6'h3;
      repeat (5) begin
        step(1);
        chk(8'({demap_q, demap_idx_q[1]}), 8'h83);
      end
      chk(8'({urgent_data_tlb_flag_q, urgent_instr_tlb_flag_q}), 8'h0);
      xl_valid = 2'h0;
      xl_set_assoc_tlb_perr = 2'h0;
      step(1);
      chk(8'({set_assoc_tlb_inval_way_q[1], set_assoc_tlb_active_q[1]}), e[w]);
      chk(8'({set_assoc_tlb_active_q[0], degradation_error_flag_q}), 8'h7);
    end
  endtask

  task automatic t_full_assoc_tlb();
    for (int t = 0; t < 2; t++) begin
      xl(t, 16'h0, 3'(3 * t));
      chk(8'(full_assoc_tlb_locked_q), 8'(2 * t));
      chk(8'({full_assoc_tlb_hit_q, data_access_err_q, instr_access_err_q}), 8'(5 << t));
      chk(8'(t == 0 ? instruction_fault_status_q : data_fault_status_q),
          8'h45 + 8'(t));
      step(1);
      chk(8'({data_access_err_q, instr_access_err_q}), 8'h0);
    end
    xl(1, 16'h0001, 3'h6);
    chk(8'({full_assoc_tlb_hit_q, full_assoc_tlb_lock_miss_q, data_access_err_q}), 8'h04);
    chk(8'(data_fault_status_q), 8'h46);
    step(1);
    xl(1, 16'h0001, 3'h1);
    chk(8'({full_assoc_tlb_hit_q, full_assoc_tlb_lock_miss_q, data_access_err_q}), 8'h00);
  endtask

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge sys_clk);
    #1 srst = 1'b0;
    step(2);
    chk(8'({l1i_active_q, l1d_active_q, l2_active_q}), 8'hFF);
    chk(8'({set_assoc_tlb_active_q[0], set_assoc_tlb_active_q[1], l2_pending_q}), 8'hF0);
    chk(8'({degradation_error_flag_q, data_fault_status_q}), 8'h00);
    t_thresh();
    t_l1();
    t_l2();
    t_asi();
    t_set_assoc_tlb();
    t_full_assoc_tlb();
    summarize();
  end

  // Whole run is under a thousand cycles; this leaves a wide margin
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
endmodule
